// >>> rtl/oneshot_pulse_pkg.sv
// constants and types for the one-shot pulse channel
// assumes a single clock domain and a tick enable from an external divider
//
// Overview of operation
// - counter write starts new sequence from value
// - output inactive in initial phase, then pulse
// - initial phase lasts period compare minus start
// - at period minus one: active edge, clear
// - at duty minus one during pulse: inactive edge
// - both comparators also fire in initial phase
// - triggers set flags; enabled flags raise irq
// - first pulse delivers every match trigger
// - later pulses trigger exactly like the first
// - disable or channel reset returns to idle; only channel reset clears flags
package oneshot_pulse_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int CNT_W = 16;
    localparam int IRQ_W = 2;

    // ------------------------------------------------------------
    // flag bit positions
    // ------------------------------------------------------------
    localparam int PERIOD_BIT = 0;
    localparam int DUTY_BIT   = 1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] CNT_RST  = 16'h0000;
    localparam logic [IRQ_W-1:0] FLAG_RST = 2'h0;

    // ------------------------------------------------------------
    // sequence states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_INIT  = 4'h2,
        ST_PULSE = 4'h4,
        ST_DONE  = 4'h8
    } seq_state_t;

endpackage : oneshot_pulse_pkg

// >>> rtl/oneshot_pulse_channel.sv
// one timer output channel running a one-shot pulse sequence
// assumes tick_en is a one-cycle enable from the selected clock divider
`timescale 1ns/1ps
module oneshot_pulse_channel
    import oneshot_pulse_pkg::*;
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // selected clock tick
    input  wire logic             tick_en,
    // channel control
    input  wire logic             chan_enable,
    input  wire logic             chan_reset,
    input  wire logic             oneshot_enable,
    input  wire logic             active_high,
    // counter write port
    input  wire logic             cnt_wr,
    input  wire logic [CNT_W-1:0] cnt_wr_data,
    // compare values
    input  wire logic [CNT_W-1:0] period_compare,
    input  wire logic [CNT_W-1:0] duty_compare,
    // interrupt control
    input  wire logic [IRQ_W-1:0] channel_irq_enables,
    input  wire logic [IRQ_W-1:0] irq_clear,
    // channel output and status
    output logic                  chan_out,
    output logic [CNT_W-1:0]      pulse_counter,
    output logic                  seq_busy,
    output logic                  period_match_trigger,
    output logic                  duty_match_trigger,
    output logic [IRQ_W-1:0]      channel_irq_flags,
    output logic                  period_match_irq,
    output logic                  duty_match_irq
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic hits(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] cmp);
        hits = (cnt == cmp - 16'h0001);
    endfunction : hits

    seq_state_t       state_reg;
    seq_state_t       state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             active_reg;
    logic             active_next;
    logic             idle_force;
    logic             start;
    logic             running;
    logic             period_hit;
    logic             duty_hit;
    logic [IRQ_W-1:0] hit_vec;
    logic [IRQ_W-1:0] flags_next;

    assign idle_force = !chan_enable || chan_reset;
    assign start      = cnt_wr && !idle_force;
    assign running    = (state_reg == ST_INIT) || (state_reg == ST_PULSE);
    // comparators stay live in initial phase; no history is kept
    assign period_hit = running && tick_en && hits(cnt_reg, period_compare);
    assign duty_hit   = running && tick_en && hits(cnt_reg, duty_compare);
    assign hit_vec    = {duty_hit, period_hit};

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        active_next = active_reg;
        if (idle_force) begin
            state_next  = ST_IDLE;
            cnt_next    = CNT_RST;
            active_next = 1'b0;
        end else if (start) begin
            state_next  = ST_INIT;
            cnt_next    = cnt_wr_data;
            active_next = 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    state_next = ST_IDLE;
                end
                ST_INIT: begin
                    if (tick_en) begin
                        if (period_hit) begin
                            state_next  = ST_PULSE;
                            cnt_next    = CNT_RST;
                            active_next = 1'b1;
                        end else begin
                            cnt_next = cnt_reg + 16'h0001;
                        end
                    end
                end
                ST_PULSE: begin
                    if (tick_en) begin
                        if (period_hit && !oneshot_enable) begin
                            cnt_next    = CNT_RST;
                            active_next = 1'b1;
                        end else if (duty_hit || period_hit) begin
                            active_next = 1'b0;
                            if (oneshot_enable) begin
                                state_next = ST_DONE;
                            end else begin
                                cnt_next = cnt_reg + 16'h0001;
                            end
                        end else begin
                            cnt_next = cnt_reg + 16'h0001;
                        end
                    end
                end
                ST_DONE: begin
                    state_next  = ST_DONE;
                    active_next = 1'b0;
                end
                default: begin
                    state_next  = ST_IDLE;
                    cnt_next    = CNT_RST;
                    active_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg  <= ST_IDLE;
            cnt_reg    <= CNT_RST;
            active_reg <= 1'b0;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            active_reg <= active_next;
        end
    end

    // ------------------------------------------------------------
    // output pins
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            chan_out      <= 1'b0;
            pulse_counter <= CNT_RST;
            seq_busy      <= 1'b0;
        end else begin
            chan_out      <= active_next ? active_high : !active_high;
            pulse_counter <= cnt_next;
            seq_busy      <= (state_next == ST_INIT) || (state_next == ST_PULSE);
        end
    end

    // ------------------------------------------------------------
    // triggers, flags and interrupts
    // ------------------------------------------------------------
    // set wins over a clear in the same cycle
    assign flags_next = chan_reset ? FLAG_RST : ((channel_irq_flags & ~irq_clear) | hit_vec);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            period_match_trigger <= 1'b0;
            duty_match_trigger   <= 1'b0;
        end else begin
            period_match_trigger <= period_hit;
            duty_match_trigger   <= duty_hit;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            channel_irq_flags <= FLAG_RST;
            period_match_irq  <= 1'b0;
            duty_match_irq    <= 1'b0;
        end else begin
            channel_irq_flags <= flags_next;
            period_match_irq  <= flags_next[PERIOD_BIT] && channel_irq_enables[PERIOD_BIT];
            duty_match_irq    <= flags_next[DUTY_BIT] && channel_irq_enables[DUTY_BIT];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [CNT_W-1:0] start_val_reg;
    logic [CNT_W-1:0] init_ticks_reg;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            start_val_reg  <= CNT_RST;
            init_ticks_reg <= CNT_RST;
        end else if (start) begin
            start_val_reg  <= cnt_wr_data;
            init_ticks_reg <= CNT_RST;
        end else if (state_reg == ST_INIT && tick_en) begin
            init_ticks_reg <= init_ticks_reg + 16'h0001;
        end
    end

    // a start value one short of the period must still match on its first tick
    logic late_start_reg;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            late_start_reg <= 1'b0;
        end else if (idle_force) begin
            late_start_reg <= 1'b0;
        end else if (start) begin
            late_start_reg <= (cnt_wr_data == period_compare - 16'h0001);
        end else if (tick_en) begin
            late_start_reg <= 1'b0;
        end
    end

    sequence seq_late_first_tick;
        late_start_reg && (state_reg == ST_INIT) && !idle_force && !cnt_wr && tick_en;
    endsequence

    sequence seq_init_count;
        (state_reg == ST_INIT) && !idle_force && !cnt_wr && tick_en && !hits(cnt_reg, period_compare);
    endsequence

    sequence seq_pulse_count;
        (state_reg == ST_PULSE) && !idle_force && !cnt_wr && tick_en
            && !hits(cnt_reg, period_compare) && !hits(cnt_reg, duty_compare);
    endsequence

    sequence seq_init_edge;
        (state_reg == ST_INIT) && !idle_force && !cnt_wr && tick_en && hits(cnt_reg, period_compare);
    endsequence

    sequence seq_pulse_end;
        (state_reg == ST_PULSE) && !idle_force && !cnt_wr && tick_en && oneshot_enable
            && hits(cnt_reg, duty_compare) && !hits(cnt_reg, period_compare);
    endsequence

    AST_WRITE_STARTS: assert property (@(posedge clk) disable iff (sys_rst)
        start |=> (state_reg == ST_INIT) && (cnt_reg == $past(cnt_wr_data)))
        else $error("counter write did not start a sequence");

    AST_INIT_INACTIVE: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == ST_INIT) |=> (chan_out == !active_high) || (state_reg != ST_INIT))
        else $error("output active during initial phase");

    AST_INIT_LENGTH: assert property (@(posedge clk) disable iff (sys_rst)
        seq_init_edge |-> (16'(init_ticks_reg + 16'h0001) == 16'(period_compare - start_val_reg)))
        else $error("initial phase length wrong");

    AST_ACTIVE_EDGE: assert property (@(posedge clk) disable iff (sys_rst)
        seq_init_edge |=> (state_reg == ST_PULSE) && active_reg && (cnt_reg == CNT_RST)
            ##0 (chan_out == active_high))
        else $error("active edge missing at period match");

    AST_INACTIVE_EDGE: assert property (@(posedge clk) disable iff (sys_rst)
        seq_pulse_end |=> (state_reg == ST_DONE) && !active_reg && (chan_out == !active_high))
        else $error("inactive edge missing at duty match");

    AST_INIT_TRIGGER: assert property (@(posedge clk) disable iff (sys_rst)
        ((state_reg == ST_INIT) && tick_en && !chan_reset && hits(cnt_reg, duty_compare))
            |=> duty_match_trigger && channel_irq_flags[DUTY_BIT])
        else $error("duty trigger skipped in initial phase");

    AST_LATE_START_TRIGGER: assert property (@(posedge clk) disable iff (sys_rst)
        seq_late_first_tick |=> period_match_trigger && channel_irq_flags[PERIOD_BIT])
        else $error("period trigger skipped after late start value");

    AST_FLAG_IRQ: assert property (@(posedge clk) disable iff (sys_rst)
        (period_hit && !chan_reset && channel_irq_enables[PERIOD_BIT]) |=> period_match_trigger && period_match_irq)
        else $error("enabled period flag without irq");

    AST_DISABLE: assert property (@(posedge clk) disable iff (sys_rst)
        idle_force |=> (state_reg == ST_IDLE) && (cnt_reg == CNT_RST) && !seq_busy)
        else $error("disable did not return channel to idle");

    AST_DONE_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        ((state_reg == ST_DONE) && !cnt_wr && !idle_force)
            |=> (state_reg == ST_DONE) && $stable(cnt_reg) && !period_match_trigger)
        else $error("done state did not hold");

    AST_INIT_COUNT: assert property (@(posedge clk) disable iff (sys_rst)
        seq_init_count |=> (state_reg == ST_INIT) && (cnt_reg == 16'($past(cnt_reg) + 16'h0001)))
        else $error("counter did not advance in initial phase");

    AST_PULSE_COUNT: assert property (@(posedge clk) disable iff (sys_rst)
        seq_pulse_count |=> (state_reg == ST_PULSE) && (cnt_reg == 16'($past(cnt_reg) + 16'h0001)))
        else $error("counter did not resume counting in the pulse");

    AST_TICK_ONLY: assert property (@(posedge clk) disable iff (sys_rst)
        (running && !tick_en && !idle_force && !cnt_wr) |=> $stable(cnt_reg) && (state_reg == $past(state_reg)))
        else $error("counter moved without a tick");

    AST_PERIOD_TRIGGER: assert property (@(posedge clk) disable iff (sys_rst)
        seq_init_edge |=> period_match_trigger && channel_irq_flags[PERIOD_BIT])
        else $error("period trigger missing at end of initial phase");

    AST_DUTY_IRQ: assert property (@(posedge clk) disable iff (sys_rst)
        (duty_hit && !chan_reset && channel_irq_enables[DUTY_BIT]) |=> duty_match_trigger && duty_match_irq)
        else $error("enabled duty match without irq");

    AST_SET_BEATS_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
        (period_hit && !chan_reset && irq_clear[PERIOD_BIT]) |=> channel_irq_flags[PERIOD_BIT])
        else $error("flag clear overrode a period match");

    AST_QUIET_WHEN_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
        !running |=> !period_match_trigger && !duty_match_trigger)
        else $error("trigger fired outside a sequence");

    AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        ((state_reg == ST_IDLE) && !start) |=> (state_reg == ST_IDLE) && !active_reg && !seq_busy)
        else $error("idle channel left idle without a start");

endmodule : oneshot_pulse_channel

// >>> verification/oneshot_pulse_channel_tb.sv
// self-checking bench for the one-shot pulse channel
// assumes the channel design and its package are compiled first
`timescale 1ns/1ps
module oneshot_pulse_channel_tb import oneshot_pulse_pkg::*;;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    typedef struct {
        logic [CNT_W-1:0] p;
        logic [CNT_W-1:0] d;
        logic [CNT_W-1:0] w;
        logic             ah;
        logic [IRQ_W-1:0] en;
        int               div;
    } row_t;
    logic             clk, sys_rst, tick_en, chan_enable, chan_reset, oneshot_enable, active_high, cnt_wr;
    logic [CNT_W-1:0] cnt_wr_data, period_compare, duty_compare, pulse_counter;
    logic [IRQ_W-1:0] channel_irq_enables, irq_clear, channel_irq_flags;
    logic             chan_out, seq_busy, period_match_trigger, duty_match_trigger, period_match_irq, duty_match_irq;
    int               num_errors, samples_checked, tick_div, tick_cnt, rises, act;
    logic             prev;
    row_t             rows [5] = '{'{16'h4, 16'h1, 16'h2, 1'h1, 2'h3, 1}, '{16'hA, 16'h0, 16'h3, 1'h0, 2'h1, 1},
                                   '{16'h8, 16'h5, 16'h3, 1'h1, 2'h2, 3}, '{16'h6, 16'h5, 16'h1, 1'h1, 2'h0, 1},
                                   '{16'h14, 16'h2, 16'hA, 1'h0, 2'h3, 2}};

    oneshot_pulse_channel dut (.clk(clk), .sys_rst(sys_rst), .tick_en(tick_en), .chan_enable(chan_enable),
        .chan_reset(chan_reset), .oneshot_enable(oneshot_enable), .active_high(active_high), .cnt_wr(cnt_wr),
        .cnt_wr_data(cnt_wr_data), .period_compare(period_compare), .duty_compare(duty_compare),
        .channel_irq_enables(channel_irq_enables), .irq_clear(irq_clear), .chan_out(chan_out),
        .pulse_counter(pulse_counter), .seq_busy(seq_busy), .period_match_trigger(period_match_trigger),
        .duty_match_trigger(duty_match_trigger), .channel_irq_flags(channel_irq_flags),
        .period_match_irq(period_match_irq), .duty_match_irq(duty_match_irq));

    // ------------------------------------------------------------
    // clock and selected tick
    // ------------------------------------------------------------
    always #20 clk = ~clk;
    always @(posedge clk) begin
        #1 tick_cnt = (tick_cnt + 1) % tick_div;
        tick_en = (tick_cnt == 0);
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("checks=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    task automatic do_reset(input int cyc);
        sys_rst = 1'b1;
        repeat (cyc) @(posedge clk);
        #2 chk({chan_out, seq_busy, period_match_trigger, duty_match_trigger, channel_irq_flags}, 16'h0);
        chk(pulse_counter, 16'h0);
        @(posedge clk);
        #1 sys_rst = 1'b0;
        @(posedge clk);
        #2 chk(chan_out, !active_high);
    endtask : do_reset

    // one complete one-shot run, measured in selected ticks
    task automatic run_row(input row_t r);
        int n, ti, tp, np, nd;
        logic seen;
        ti = 0; tp = 0; np = 0; nd = 0; seen = 1'b0;
        @(posedge clk);
        #1 tick_div = r.div;
        period_compare = r.p; duty_compare = r.w; active_high = r.ah; channel_irq_enables = r.en;
        irq_clear = 2'h3;
        @(posedge clk);
        #1 irq_clear = 2'h0;
        cnt_wr = 1'b1;
        cnt_wr_data = r.d;
        @(posedge clk);
        #1 cnt_wr = 1'b0;
        #1 chk(pulse_counter, r.d);
        for (n = 0; n < 4000; n++) begin
            np += int'(period_match_trigger);
            nd += int'(duty_match_trigger);
            if (seen && !seq_busy) break;
            if (chan_out === r.ah) begin
                seen = 1'b1;
                if (tick_en) tp++;
            end else if (seq_busy && tick_en) ti++;
            @(posedge clk);
            #2;
        end
        if (n == 4000) begin
            num_errors++;
            return;
        end
        chk(ti, r.p - r.d);
        chk(tp, r.w);
        chk(np, 1);
        chk(nd, (r.w - 1 >= r.d) ? 2 : 1);
        chk(channel_irq_flags, 2'h3);
        chk({duty_match_irq, period_match_irq}, r.en);
        repeat (5) @(posedge clk);
        #2 chk(pulse_counter, r.w - 1);
        chk({seq_busy, chan_out}, {1'b0, !r.ah});
    endtask : run_row

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0; sys_rst = 1'b1; tick_en = 1'b0; chan_enable = 1'b1; chan_reset = 1'b0;
        oneshot_enable = 1'b1; active_high = 1'b1; cnt_wr = 1'b0; cnt_wr_data = 16'h0;
        period_compare = 16'h4; duty_compare = 16'h2; channel_irq_enables = 2'h0; irq_clear = 2'h0;
        num_errors = 0; samples_checked = 0; tick_div = 1; tick_cnt = 0;
        do_reset(10);
        foreach (rows[i]) run_row(rows[i]);
        // a write while disabled is ignored and flags survive the disable
        @(posedge clk);
        #1 chan_enable = 1'b0;
        @(posedge clk);
        #1 cnt_wr = 1'b1;
        cnt_wr_data = 16'h7;
        @(posedge clk);
        #1 cnt_wr = 1'b0;
        #1 chk(pulse_counter, 16'h0);
        chk(seq_busy, 16'h0);
        chk(channel_irq_flags, 2'h3);
        @(posedge clk);
        #1 chan_reset = 1'b1;
        @(posedge clk);
        #1 chan_reset = 1'b0;
        chan_enable = 1'b1;
        #1 chk(channel_irq_flags, 2'h0);
        run_row(rows[0]);
        // restart in mid initial phase from a new start value
        @(posedge clk);
        #1 period_compare = 16'h14;
        cnt_wr = 1'b1;
        cnt_wr_data = 16'h0;
        @(posedge clk);
        #1 cnt_wr = 1'b0;
        repeat (3) @(posedge clk);
        run_row('{16'h14, 16'hF, 16'hA, 1'h1, 2'h3, 1});
        // continuous mode repeats the pulse each period; a match beats a clear
        @(posedge clk);
        #1 oneshot_enable = 1'b0;
        period_compare = 16'h4;
        duty_compare = 16'h2;
        cnt_wr = 1'b1;
        cnt_wr_data = 16'h3;
        @(posedge clk);
        #1 cnt_wr = 1'b0;
        #1 prev = chan_out;
        rises = 0;
        act = 0;
        for (int k = 1; k <= 16; k++) begin
            @(posedge clk);
            #1 irq_clear = (k == 4) ? 2'h3 : 2'h0;
            #1 rises += int'(chan_out && !prev);
            act += int'(chan_out);
            prev = chan_out;
            if (k == 5) begin
                chk(channel_irq_flags, 2'h1);
                chk({duty_match_irq, period_match_irq}, 2'h1);
            end
        end
        chk(rises, 4);
        chk(act, 8);
        chk(seq_busy, 1'b1);
        // reset in the middle of a sequence
        @(posedge clk);
        #1 oneshot_enable = 1'b1;
        cnt_wr = 1'b1;
        @(posedge clk);
        #1 cnt_wr = 1'b0;
        do_reset(2);
        conclude();
    end
endmodule : oneshot_pulse_channel_tb
